// *** hdl/bdma_top.sv ***
// Summary of operation
// - access window is bank 0 bottom 96 bytes plus bank 15 top 160 bytes.
// - one instruction bit picks the banked space or the access window.
// - with access bit 0, offset after the low part lands on the high part.
// - sixteen banks; banked direct addressing reaches them through bank select only.
// - bank select low four bits form the top four address bits.
// - bank select upper 28 bits read zero; writing them does nothing.
// - unimplemented bank reads zero and drops writes; flags still update.
// - each bank holds 256 bytes, offsets 00h to FFh.
// - file-to-file move ignores bank select and uses full 12-bit addresses.
// - a load-bank-literal instruction writes the bank select register.
`timescale 1ns/1ps
`default_nettype none
`include "bdma_map.svh"

module bdma_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_valid,
    output logic core_ready,
    input wire logic [1:0] core_op,
    input wire logic core_access_sel,
    input wire logic [7:0] core_offset,
    input wire logic [3:0] core_literal,
    input wire logic [11:0] core_src_addr,
    input wire logic [11:0] core_dst_addr,
    input wire logic [7:0] core_wdata,
    output logic core_done,
    output logic [7:0] core_rdata,
    output logic [11:0] core_addr,
    output logic core_unimpl
);
    // byte storage for the implemented banks only
    logic [7:0] mem [0:`BDMA_SLOTS*256-1];

    logic [3:0] bank_reg;
    logic [3:0] bank_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic done_reg;
    logic done_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [11:0] addr_reg;
    logic [11:0] addr_next;
    logic unimpl_reg;
    logic unimpl_next;
    logic drop_reg;
    logic drop_next;

    logic mem_we;
    logic [9:0] mem_widx;
    logic [7:0] mem_wdata;

    logic take;
    logic apb_setup;
    logic apb_wr;
    logic apb_mapped;
    bdma_pkg::bdma_op_t op;
    bdma_pkg::bdma_addr_t direct_addr;
    bdma_pkg::bdma_addr_t eff_addr;
    bdma_pkg::bdma_addr_t src_addr;
    logic [7:0] src_byte;
    logic [7:0] rd_byte;

    bdma_addr_if aif ();

    assign aif.access_sel = core_access_sel;
    assign aif.offset = core_offset;
    assign aif.bank = bank_reg;

    bdma_addr_former u_former (
        .aif(aif.former)
    );

    // reads of a missing bank come back as zero
    function automatic logic [7:0] read_byte(input bdma_pkg::bdma_addr_t a);
        logic [7:0] v;
        v = 8'h00;
        if (bdma_pkg::bank_present(a[11:8])) begin
            v = mem[{bdma_pkg::bank_slot(a[11:8]), a[7:0]}];
        end
        return v;
    endfunction

    // one op per cycle, so the core is never stalled
    assign core_ready = 1'b1;
    assign take = core_valid;
    assign op = bdma_pkg::bdma_op_t'(core_op);
    assign direct_addr = aif.addr;
    assign src_addr = core_src_addr;
    // always_comb follows what the function reads, so a fresh memory write is seen too
    always_comb begin
        src_byte = read_byte(src_addr);
        rd_byte = read_byte(direct_addr);
    end

    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;
    assign apb_mapped = (paddr == `BDMA_BANK_SEL_ADDR) ||
                        (paddr == `BDMA_STATUS_ADDR) ||
                        (paddr == `BDMA_ID_ADDR);

    // zero wait states keep the core and the bus on the same cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !apb_mapped;

    always_comb begin
        eff_addr = direct_addr;
        if (op == bdma_pkg::BDMA_OP_MOVE) begin
            // move takes its own addresses, bank select plays no part
            eff_addr = core_dst_addr;
        end
    end

    // memory write path
    always_comb begin
        mem_we = 1'b0;
        mem_widx = {bdma_pkg::bank_slot(eff_addr[11:8]), eff_addr[7:0]};
        mem_wdata = core_wdata;
        if (take && bdma_pkg::bank_present(eff_addr[11:8])) begin
            if (op == bdma_pkg::BDMA_OP_WRITE) begin
                mem_we = 1'b1;
            end else if (op == bdma_pkg::BDMA_OP_MOVE) begin
                mem_we = 1'b1;
                mem_wdata = src_byte;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[mem_widx] <= mem_wdata;
        end
    end

    // bank select and core answer
    always_comb begin
        bank_next = bank_reg;
        done_next = 1'b0;
        rdata_next = rdata_reg;
        addr_next = addr_reg;
        unimpl_next = unimpl_reg;
        drop_next = drop_reg;
        if (apb_wr && paddr == `BDMA_BANK_SEL_ADDR) begin
            // only the low nibble is stored, the rest is dropped
            bank_next = pwdata[`BDMA_BANK_MSB:0];
        end
        if (apb_wr && paddr == `BDMA_STATUS_ADDR && pwdata[`BDMA_ST_DROP_BIT]) begin
            drop_next = 1'b0;
        end
        if (take) begin
            done_next = 1'b1;
            unique case (op)
                bdma_pkg::BDMA_OP_LOAD_BANK: begin
                    // the core wins over a same-cycle bus write
                    bank_next = core_literal;
                    rdata_next = 8'h00;
                end
                bdma_pkg::BDMA_OP_READ: begin
                    rdata_next = rd_byte;
                    addr_next = direct_addr;
                    unimpl_next = !bdma_pkg::bank_present(direct_addr[11:8]);
                end
                bdma_pkg::BDMA_OP_WRITE: begin
                    rdata_next = 8'h00;
                    addr_next = direct_addr;
                    unimpl_next = !bdma_pkg::bank_present(direct_addr[11:8]);
                    if (!bdma_pkg::bank_present(direct_addr[11:8])) begin
                        drop_next = 1'b1;
                    end
                end
                bdma_pkg::BDMA_OP_MOVE: begin
                    rdata_next = src_byte;
                    addr_next = core_dst_addr;
                    unimpl_next = !bdma_pkg::bank_present(core_dst_addr[11:8]);
                    if (!bdma_pkg::bank_present(core_dst_addr[11:8])) begin
                        drop_next = 1'b1;
                    end
                end
            endcase
        end
    end

    // register read data is captured in the setup phase
    always_comb begin
        prdata_next = prdata_reg;
        if (apb_setup) begin
            prdata_next = 32'h0000_0000;
            if (paddr == `BDMA_BANK_SEL_ADDR) begin
                prdata_next = {28'h000_0000, bank_reg};
            end else if (paddr == `BDMA_STATUS_ADDR) begin
                prdata_next = {18'h0_0000, drop_reg, unimpl_reg, addr_reg};
            end else if (paddr == `BDMA_ID_ADDR) begin
                prdata_next = `BDMA_ID_VALUE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_reg <= `BDMA_BANK_RST;
            prdata_reg <= 32'h0000_0000;
            done_reg <= 1'b0;
            rdata_reg <= 8'h00;
            addr_reg <= 12'h000;
            unimpl_reg <= 1'b0;
            drop_reg <= 1'b0;
        end else begin
            bank_reg <= bank_next;
            prdata_reg <= prdata_next;
            done_reg <= done_next;
            rdata_reg <= rdata_next;
            addr_reg <= addr_next;
            unimpl_reg <= unimpl_next;
            drop_reg <= drop_next;
        end
    end

    assign prdata = prdata_reg;
    assign core_done = done_reg;
    assign core_rdata = rdata_reg;
    assign core_addr = addr_reg;
    assign core_unimpl = unimpl_reg;
endmodule // bdma_top

`default_nettype wire

// *** hdl/bdma_map.svh ***
`ifndef BDMA_MAP_SVH
`define BDMA_MAP_SVH

// apb register byte addresses
`define BDMA_BANK_SEL_ADDR 12'h000
`define BDMA_STATUS_ADDR 12'h004
`define BDMA_ID_ADDR 12'h008

// bank select field layout and reset value
`define BDMA_BANK_MSB 3
`define BDMA_BANK_RST 4'h0

// status register fields
`define BDMA_ST_ADDR_MSB 11
`define BDMA_ST_UNIMPL_BIT 12
`define BDMA_ST_DROP_BIT 13

// access window split and high base bank
`define BDMA_LOW_LIMIT 8'h60
`define BDMA_HIGH_BANK 4'hf
`define BDMA_LOW_BANK 4'h0

// implemented banks: 0..2 plus the sfr bank
`define BDMA_IMPL_LOW_BANKS 4'h3
`define BDMA_SLOTS 4

// block id, value is arbitrary
`define BDMA_ID_VALUE 32'h0000_a5c3

`endif

// *** hdl/bdma_pkg.sv ***
package bdma_pkg;

    typedef enum logic [1:0] {
        BDMA_OP_READ = 2'b00,
        BDMA_OP_WRITE = 2'b01,
        BDMA_OP_LOAD_BANK = 2'b10,
        BDMA_OP_MOVE = 2'b11
    } bdma_op_t;

    typedef logic [3:0] bdma_bank_t;
    typedef logic [11:0] bdma_addr_t;

    // true when the bank has storage behind it
    function automatic logic bank_present(input bdma_bank_t bank);
        return (bank < 4'h3) || (bank == 4'hf);
    endfunction

    // storage slot of a present bank
    function automatic logic [1:0] bank_slot(input bdma_bank_t bank);
        return (bank == 4'hf) ? 2'b11 : bank[1:0];
    endfunction

endpackage

// *** hdl/bdma_addr_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface bdma_addr_if;
    logic access_sel;
    logic [7:0] offset;
    logic [3:0] bank;
    logic [11:0] addr;

    modport former (
        input access_sel,
        input offset,
        input bank,
        output addr
    );

    modport user (
        output access_sel,
        output offset,
        output bank,
        input addr
    );
endinterface

`default_nettype wire

// *** hdl/bdma_addr_former.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bdma_map.svh"

module bdma_addr_former (
    bdma_addr_if.former aif
);
    always_comb begin
        if (aif.access_sel) begin
            // banked: bank select gives the top four address bits
            aif.addr = {aif.bank, aif.offset};
        end else if (aif.offset < `BDMA_LOW_LIMIT) begin
            aif.addr = {`BDMA_LOW_BANK, aif.offset};
        end else begin
            // low part runs straight on into the sfr part
            aif.addr = {`BDMA_HIGH_BANK, aif.offset};
        end
    end
endmodule // bdma_addr_former

`default_nettype wire

// *** testbench/bdma_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module bdma_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic core_valid,
    input wire logic [1:0] core_op,
    input wire logic core_access_sel,
    input wire logic [7:0] core_offset,
    input wire logic [11:0] core_dst_addr,
    input wire logic core_done,
    input wire logic [7:0] core_rdata,
    input wire logic [11:0] core_addr,
    input wire logic core_unimpl
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic dir_win = core_valid && !core_op[1] && !core_access_sel;

    property p_load; core_valid && core_op == 2'h2 |=> core_done && $stable(core_addr); endproperty
    a_load: assert property (p_load) else $error("bank load misbehaved");
    property p_low; dir_win && core_offset < 8'h60 |=> core_addr == {4'h0, $past(core_offset)}; endproperty
    a_low: assert property (p_low) else $error("window low address wrong");
    property p_high; dir_win && core_offset >= 8'h60 |=> core_addr == {4'hf, $past(core_offset)}; endproperty
    a_high: assert property (p_high) else $error("window high address wrong");
    property p_move; core_valid && core_op == 2'h3 |=> core_addr == $past(core_dst_addr); endproperty
    a_move: assert property (p_move) else $error("move address wrong");
    property p_off; core_valid && !core_op[1] && core_access_sel |=> core_addr[7:0] == $past(core_offset); endproperty
    a_off: assert property (p_off) else $error("in-bank offset wrong");
    property p_unimpl; core_valid && !core_op[1] |=> core_unimpl == (core_addr[11:8] > 4'h2 && core_addr[11:8] != 4'hf); endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented flag wrong");
    property p_zero; core_valid && core_op == 2'h0 ##1 core_unimpl |-> core_rdata == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("absent bank read not zero");
    property p_upper; psel && !penable && !pwrite && paddr == 12'h000 |=> prdata[31:4] == 28'h000_0000; endproperty
    a_upper: assert property (p_upper) else $error("bank select upper bits set");
endmodule // bdma_chk

bind bdma_top bdma_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .core_valid(core_valid), .core_op(core_op), .core_access_sel(core_access_sel),
    .core_offset(core_offset), .core_dst_addr(core_dst_addr), .core_done(core_done), .core_rdata(core_rdata),
    .core_addr(core_addr), .core_unimpl(core_unimpl));

`default_nettype wire

// *** testbench/bdma_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module bdma_core_model (
    input wire logic pclk,
    output logic core_valid,
    output logic [1:0] core_op,
    output logic core_access_sel,
    output logic [7:0] core_offset,
    output logic [3:0] core_literal,
    output logic [11:0] core_src_addr,
    output logic [11:0] core_dst_addr,
    output logic [7:0] core_wdata
);
    initial {core_valid, core_op, core_access_sel, core_offset, core_literal, core_src_addr, core_dst_addr, core_wdata} = '0;

    // move source rides in {lit, off} to keep the call short
    task automatic issue(input logic [1:0] op, input logic sel, input logic [7:0] off, input logic [3:0] lit,
                         input logic [7:0] wd, input logic [11:0] dst);
        @(posedge pclk);
        core_valid <= 1'h1;
        core_op <= op;
        core_access_sel <= sel;
        core_offset <= off;
        core_literal <= lit;
        core_src_addr <= {lit, off};
        core_dst_addr <= dst;
        core_wdata <= wd;
        @(posedge pclk);
        core_valid <= 1'h0;
        // core_offset and core_wdata do not keep the last value when idle, so stale decode shows up
        core_offset <= ~off;
        core_wdata <= ~wd;
    endtask
endmodule // bdma_core_model

`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
    typedef struct packed {logic [1:0] op; logic sel; logic [7:0] off; logic [3:0] lit; logic [7:0] wd;
        logic [11:0] ea; logic [7:0] ed; logic eu;} bdma_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_valid, core_ready, core_access_sel;
    logic core_done, core_unimpl, err;
    logic [11:0] paddr, core_src_addr, core_dst_addr, core_addr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] core_op;
    logic [7:0] core_offset, core_wdata, core_rdata;
    logic [3:0] core_literal;
    int n_errors = 0, n_compared = 0, cyc = 0;
    bdma_row_t rows [12] = '{
        '{2'h2, 1'h0, 8'h00, 4'h1, 8'h00, 12'h000, 8'h00, 1'h0},
        '{2'h1, 1'h1, 8'h10, 4'h0, 8'ha5, 12'h110, 8'h00, 1'h0},
        '{2'h0, 1'h1, 8'h10, 4'h0, 8'h00, 12'h110, 8'ha5, 1'h0},
        '{2'h1, 1'h0, 8'h5f, 4'h0, 8'h3c, 12'h05f, 8'h00, 1'h0},
        '{2'h1, 1'h0, 8'h60, 4'h0, 8'hc3, 12'hf60, 8'h00, 1'h0},
        '{2'h3, 1'h1, 8'h60, 4'hf, 8'h00, 12'h220, 8'hc3, 1'h0},
        '{2'h2, 1'h0, 8'h00, 4'h2, 8'h00, 12'h220, 8'h00, 1'h0},
        '{2'h0, 1'h1, 8'h20, 4'h0, 8'h00, 12'h220, 8'hc3, 1'h0},
        '{2'h0, 1'h0, 8'h5f, 4'h0, 8'h00, 12'h05f, 8'h3c, 1'h0},
        '{2'h2, 1'h0, 8'h00, 4'h7, 8'h00, 12'h05f, 8'h00, 1'h0},
        '{2'h1, 1'h1, 8'hff, 4'h0, 8'h77, 12'h7ff, 8'h00, 1'h1},
        '{2'h0, 1'h1, 8'hff, 4'h0, 8'h00, 12'h7ff, 8'h00, 1'h1}};

    bdma_top u_bdma_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_valid(core_valid), .core_ready(core_ready), .core_op(core_op), .core_access_sel(core_access_sel),
        .core_offset(core_offset), .core_literal(core_literal), .core_src_addr(core_src_addr),
        .core_dst_addr(core_dst_addr), .core_wdata(core_wdata), .core_done(core_done),
        .core_rdata(core_rdata), .core_addr(core_addr), .core_unimpl(core_unimpl));
    bdma_core_model u_bdma_core_model (.pclk(pclk), .core_valid(core_valid), .core_op(core_op),
        .core_access_sel(core_access_sel), .core_offset(core_offset), .core_literal(core_literal),
        .core_src_addr(core_src_addr), .core_dst_addr(core_dst_addr), .core_wdata(core_wdata));

    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (exp !== got) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic complete_run;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            complete_run;
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 12'h000, 32'h0);
        chk("bank reset", 32'h0, rd);
        apb(1'h1, 12'h000, 32'hffff_fff2);
        apb(1'h0, 12'h000, 32'h0);
        chk("bank upper", 32'h0000_0002, rd);
        chk("core_ready", 32'h1, {31'h0, core_ready});
        for (int i = 0; i < 12; i++) begin
            u_bdma_core_model.issue(rows[i].op, rows[i].sel, rows[i].off, rows[i].lit, rows[i].wd, rows[i].ea);
            // outputs settle after the take edge, so look half a cycle later
            @(negedge pclk);
            chk("core_done", 32'h1, {31'h0, core_done});
            chk("core_addr", {20'h0, rows[i].ea}, {20'h0, core_addr});
            chk("core_rdata", {24'h0, rows[i].ed}, {24'h0, core_rdata});
            chk("core_unimpl", {31'h0, rows[i].eu}, {31'h0, core_unimpl});
        end
        @(negedge pclk);
        chk("core_done low", 32'h0, {31'h0, core_done});
        apb(1'h0, 12'h004, 32'h0);
        chk("status", 32'h0000_37ff, rd);
        chk("status err", 32'h0, {31'h0, err});
        apb(1'h1, 12'h004, 32'h0000_2000);
        apb(1'h0, 12'h004, 32'h0);
        chk("status clear", 32'h0000_17ff, rd);
        apb(1'h0, 12'h00c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        // second reset in mid-run, bank select holds 7 before it
        @(posedge pclk);
        presetn <= 1'h0;
        @(negedge pclk);
        chk("rst core_addr", 32'h0, {20'h0, core_addr});
        chk("rst core_unimpl", 32'h0, {31'h0, core_unimpl});
        chk("rst core_done", 32'h0, {31'h0, core_done});
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 12'h000, 32'h0);
        chk("bank after rst", 32'h0, rd);
        complete_run;
    end
endmodule // tb

`default_nettype wire
